// *** rtl/spi_pkg.sv ***
package spi_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] status_off = 8'h10;
    localparam logic [7:0] tx_data_off = 8'h0c;
    localparam logic [7:0] rx_data_off = 8'h08;
    localparam logic [7:0] irq_enable_set_off = 8'h14;
    localparam logic [7:0] irq_enable_clear_off = 8'h18;
    localparam logic [7:0] irq_enable_state_off = 8'h1c;
    localparam logic [7:0] select_cfg0_off = 8'h30;
    localparam logic [7:0] flag_input_off = 8'h20;
    // ------------------------------------------------------------
    // Flag bit positions
    // ------------------------------------------------------------
    localparam int rx_holding_full_bit = 0;
    localparam int tx_holding_empty_bit = 1;
    localparam int mode_fault_bit = 2;
    localparam int overrun_bit = 3;
    localparam int rx_count_done_bit = 4;
    localparam int tx_count_done_bit = 5;
    localparam int rx_buffers_done_bit = 6;
    localparam int tx_buffer_drained_bit = 7;
    localparam int select_in_rise_bit = 8;
    localparam int shift_path_empty_bit = 9;
    localparam int enabled_bit = 16;
    localparam int flag_count = 10;
    // ------------------------------------------------------------
    // Control and transmit data fields
    // ------------------------------------------------------------
    localparam int ctrl_enable_bit = 0;
    localparam int ctrl_disable_bit = 1;
    localparam int final_char_bit = 24;
    localparam int tx_pcs_lsb = 16;
    // ------------------------------------------------------------
    // Select config fields
    // ------------------------------------------------------------
    localparam int idle_level_bit = 0;
    localparam int phase_sel_bit = 1;
    localparam int hold_sel_bit = 3;
    localparam int bits_lsb = 4;
    localparam int baud_lsb = 8;
    localparam int lead_lsb = 16;
    localparam int inter_lsb = 24;
    localparam logic [31:0] select_cfg_reset = 32'h0000_0000;
    localparam logic [4:0] base_bits = 5'h08;
    localparam logic [13:0] inter_char_scale = 14'h0020;
    localparam int select_count = 4;
endpackage

// *** rtl/spi_serializer.sv ***
`timescale 1ns/1ps
module spi_serializer
    import spi_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [15:0] tx_word,
    input wire logic [4:0] bit_total,
    input wire logic [7:0] baud_divider,
    input wire logic clock_idle_level,
    input wire logic clock_phase_sel,
    input wire logic miso_in,
    output logic busy,
    output logic done,
    output logic [15:0] rx_word,
    output logic serial_clock_out,
    output logic mosi_out
);
    // ------------------------------------------------------------
    // Half-period modulus counter and shifter
    // ------------------------------------------------------------
    logic [7:0] div_reg;
    logic [5:0] edge_reg;
    logic [15:0] shift_reg;
    logic sclk_reg;
    logic [7:0] half_div;
    logic tick;

    // Odd dividers round the half period down; a divider of 1 toggles each cycle
    assign half_div = (baud_divider > 8'h01) ? {1'b0, baud_divider[7:1]} : 8'h01;
    assign tick = busy && (div_reg + 8'h01 >= half_div);
    assign serial_clock_out = sclk_reg ^ clock_idle_level;
    assign mosi_out = shift_reg[15];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_reg <= 8'h00;
        end else if (start && !busy) begin
            // Preset so the first edge lands one cycle after start
            div_reg <= half_div - 8'h01;
        end else if (!busy || tick) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            done <= 1'b0;
            edge_reg <= 6'h00;
            sclk_reg <= 1'b0;
            shift_reg <= 16'h0000;
            rx_word <= 16'h0000;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy <= 1'b1;
                edge_reg <= 6'h00;
                sclk_reg <= 1'b0;
                // Left-justify so the first bit is on bit 15 for lengths up to 16
                shift_reg <= tx_word << (5'h10 - bit_total);
            end else if (tick) begin
                sclk_reg <= ~sclk_reg;
                edge_reg <= edge_reg + 6'h01;
                // Phase 1 samples on leading edges, phase 0 on trailing ones
                if (edge_reg[0] != clock_phase_sel) begin
                    rx_word <= {rx_word[14:0], miso_in};
                end else if (edge_reg != 6'h00 || clock_phase_sel) begin
                    shift_reg <= {shift_reg[14:0], 1'b0};
                end
                if (edge_reg == {bit_total, 1'b0} - 6'h01) begin
                    busy <= 1'b0;
                    sclk_reg <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule // spi_serializer

// *** rtl/spi_status_irq_chip_select.sv ***
// Functional notes
// - Select input rise sets flag until status read
// - Transmit data write clears shift-path empty
// - Shift-path empty after data, shifter, delay done
// - Status bit shows interface enabled
// - Enable, disable, mask share one bit map
// - Enable write ones set mask bits
// - Disable write ones clear mask bits
// - Mask register reads enabled sources
// - Clock idle level follows polarity bit
// - Phase bit picks change and sample edges
// - Hold bit keeps select until other select
// - Length code 0 to 8 gives 8-16 bits
// - Baud divider modulus counter sets clock rate
// - Baud divider resets to zero
// - Lead delay: half period or programmed cycles
// - Inter-character delay is 32 times setting
// - Zero inter-character delay inserts no gap
// - Final marker releases held select after char
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module spi_status_irq_chip_select
    import spi_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    input wire logic slave_select_in,
    input wire logic miso_in,
    output logic mosi_out,
    output logic serial_clock_out,
    output logic [3:0] peripheral_select_out,
    output logic irq
);
    import spi_pkg::*;

    typedef enum logic [4:0] {
        st_idle = 5'b00001,
        st_lead = 5'b00010,
        st_shift = 5'b00100,
        st_gap = 5'b01000,
        st_release = 5'b10000
    } xfer_state_t;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic enabled_reg;
    logic [flag_count-1:0] mask_reg;
    logic [31:0] cfg_reg [select_count];
    logic [15:0] tx_data_reg;
    logic [1:0] tx_sel_reg;
    logic tx_final_reg;
    logic tx_pending_reg;
    logic [15:0] rx_data_reg;
    logic rx_holding_full;
    logic mode_fault_flag;
    logic overrun_flag;
    logic select_in_rise_flag;
    logic shift_path_empty;
    logic [3:0] dma_flags_reg;
    logic ss_prev_reg;
    xfer_state_t state_reg;
    logic [1:0] cur_sel_reg;
    logic [15:0] cur_word_reg;
    logic cur_final_reg;
    logic select_active_reg;
    logic [13:0] wait_reg;
    logic [flag_count-1:0] flags;

    // ------------------------------------------------------------
    // Decode of the active select's settings
    // ------------------------------------------------------------
    logic [31:0] cur_cfg;
    logic [4:0] bit_total;
    logic [7:0] baud_divider;
    logic [7:0] lead_delay;
    logic [7:0] inter_char_delay;
    logic hold_select_after;
    logic start_shift;
    logic ser_busy;
    logic ser_done;
    logic [15:0] ser_rx;
    logic status_rd;
    logic tx_wr;
    logic [7:0] lead_cycles;

    // Start and first edge use two cycles; shorter leads stretch to two
    assign lead_cycles = (cfg_reg[tx_sel_reg][lead_lsb +: 8] == 8'h00) ?
                         {1'b0, cfg_reg[tx_sel_reg][baud_lsb + 1 +: 7]} :
                         cfg_reg[tx_sel_reg][lead_lsb +: 8];

    assign cur_cfg = cfg_reg[cur_sel_reg];
    assign bit_total = base_bits + {1'b0, cur_cfg[bits_lsb +: 4]};
    assign baud_divider = cur_cfg[baud_lsb +: 8];
    assign lead_delay = cur_cfg[lead_lsb +: 8];
    assign inter_char_delay = cur_cfg[inter_lsb +: 8];
    assign hold_select_after = cur_cfg[hold_sel_bit];
    assign status_rd = rd_en && (addr == status_off);
    assign tx_wr = wr_en && (addr == tx_data_off);
    assign start_shift = (state_reg == st_lead) && (wait_reg == 14'h0000);

    spi_serializer u_ser (
        .clk(clk),
        .rst(rst),
        .start(start_shift),
        .tx_word(cur_word_reg),
        .bit_total(bit_total),
        .baud_divider(baud_divider),
        .clock_idle_level(cur_cfg[idle_level_bit]),
        .clock_phase_sel(cur_cfg[phase_sel_bit]),
        .miso_in(miso_in),
        .busy(ser_busy),
        .done(ser_done),
        .rx_word(ser_rx),
        .serial_clock_out(serial_clock_out),
        .mosi_out(mosi_out)
    );

    // ------------------------------------------------------------
    // Control, mask and configuration writes
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enabled_reg <= 1'b0;
        end else if (wr_en && addr == ctrl_off) begin
            // Disable wins when both bits are written together
            if (wdata[ctrl_disable_bit]) begin
                enabled_reg <= 1'b0;
            end else if (wdata[ctrl_enable_bit]) begin
                enabled_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_reg <= '0;
        end else if (wr_en && addr == irq_enable_set_off) begin
            mask_reg <= mask_reg | wdata[flag_count-1:0];
        end else if (wr_en && addr == irq_enable_clear_off) begin
            mask_reg <= mask_reg & ~wdata[flag_count-1:0];
        end
    end

    generate
        for (genvar i = 0; i < select_count; i++) begin : g_cfg
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    cfg_reg[i] <= select_cfg_reset;
                end else if (wr_en && addr == select_cfg0_off + 8'(4 * i)) begin
                    cfg_reg[i] <= wdata & 32'hffff_fffb;
                end
            end
        end
    endgenerate

    // Stand-ins for the DMA counters, which live outside this block
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dma_flags_reg <= 4'h0;
        end else if (wr_en && addr == flag_input_off) begin
            dma_flags_reg <= wdata[3:0];
        end
    end

    // ------------------------------------------------------------
    // Transmit holding register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_data_reg <= 16'h0000;
            tx_sel_reg <= 2'h0;
            tx_final_reg <= 1'b0;
            tx_pending_reg <= 1'b0;
        end else begin
            if (state_reg == st_idle && tx_pending_reg && enabled_reg) begin
                tx_pending_reg <= 1'b0;
            end
            if (tx_wr) begin
                tx_data_reg <= wdata[15:0];
                tx_final_reg <= wdata[final_char_bit];
                // Lowest zero bit of the select field picks the line
                tx_sel_reg <= !wdata[tx_pcs_lsb] ? 2'h0 : !wdata[tx_pcs_lsb + 1] ? 2'h1 :
                              !wdata[tx_pcs_lsb + 2] ? 2'h2 : 2'h3;
                tx_pending_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= st_idle;
            cur_sel_reg <= 2'h0;
            cur_word_reg <= 16'h0000;
            cur_final_reg <= 1'b0;
            select_active_reg <= 1'b0;
            wait_reg <= 14'h0000;
        end else begin
            case (state_reg)
                st_idle: begin
                    if (tx_pending_reg && enabled_reg) begin
                        cur_word_reg <= tx_data_reg;
                        cur_final_reg <= tx_final_reg;
                        cur_sel_reg <= tx_sel_reg;
                        select_active_reg <= 1'b1;
                        state_reg <= st_lead;
                        // Chained characters on a held select skip the lead wait
                        if (select_active_reg && cur_sel_reg == tx_sel_reg) begin
                            wait_reg <= 14'h0000;
                        end else if (lead_cycles > 8'h02) begin
                            wait_reg <= {6'h00, lead_cycles - 8'h02};
                        end else begin
                            wait_reg <= 14'h0000;
                        end
                    end
                end
                st_lead: begin
                    if (wait_reg != 14'h0000) begin
                        wait_reg <= wait_reg - 14'h0001;
                    end else begin
                        state_reg <= st_shift;
                    end
                end
                st_shift: begin
                    if (ser_done) begin
                        wait_reg <= 14'(inter_char_scale * {6'h00, inter_char_delay});
                        state_reg <= st_gap;
                    end
                end
                st_gap: begin
                    if (wait_reg != 14'h0000) begin
                        wait_reg <= wait_reg - 14'h0001;
                    end else begin
                        state_reg <= st_release;
                    end
                end
                st_release: begin
                    // Held select stays low unless the final marker closes it
                    if (!hold_select_after || cur_final_reg) begin
                        select_active_reg <= 1'b0;
                    end
                    state_reg <= st_idle;
                end
                default: begin
                    state_reg <= st_idle;
                end
            endcase
        end
    end

    always_comb begin
        peripheral_select_out = 4'hf;
        if (select_active_reg) begin
            peripheral_select_out[cur_sel_reg] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Status flags; a set in the clearing cycle wins, except that a data write clears shift-path empty
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ss_prev_reg <= 1'b1;
            select_in_rise_flag <= 1'b0;
            mode_fault_flag <= 1'b0;
            overrun_flag <= 1'b0;
        end else begin
            ss_prev_reg <= slave_select_in;
            if (slave_select_in && !ss_prev_reg) begin
                select_in_rise_flag <= 1'b1;
            end else if (status_rd) begin
                select_in_rise_flag <= 1'b0;
            end
            if (ser_done && rx_holding_full) begin
                overrun_flag <= 1'b1;
            end else if (status_rd) begin
                overrun_flag <= 1'b0;
            end
            if (status_rd) begin
                mode_fault_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_holding_full <= 1'b0;
            rx_data_reg <= 16'h0000;
        end else if (ser_done) begin
            rx_holding_full <= 1'b1;
            rx_data_reg <= ser_rx;
        end else if (rd_en && addr == rx_data_off) begin
            rx_holding_full <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_path_empty <= 1'b1;
        end else if (tx_wr) begin
            shift_path_empty <= 1'b0;
        end else if (state_reg == st_release && !tx_pending_reg && !ser_busy) begin
            shift_path_empty <= 1'b1;
        end
    end

    assign flags = {shift_path_empty, select_in_rise_flag, dma_flags_reg,
                    overrun_flag, mode_fault_flag,
                    enabled_reg && !tx_pending_reg, rx_holding_full};
    assign irq = |(flags & mask_reg);

    // ------------------------------------------------------------
    // Read port, one cycle latency
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else if (!rd_en) begin
            rdata <= 32'h0000_0000;
        end else if (addr == status_off) begin
            rdata <= {15'h0000, enabled_reg, 6'h00, flags};
        end else if (addr == irq_enable_state_off) begin
            rdata <= {22'h000000, mask_reg};
        end else if (addr == rx_data_off) begin
            rdata <= {16'h0000, rx_data_reg};
        end else if (addr == flag_input_off) begin
            rdata <= {28'h0000000, dma_flags_reg};
        end else if (addr >= select_cfg0_off && addr < select_cfg0_off + 8'h10
                     && addr[1:0] == 2'b00) begin
            rdata <= cfg_reg[addr[3:2]];
        end else begin
            rdata <= 32'h0000_0000;
        end
    end
endmodule // spi_status_irq_chip_select

// *** verification/spi_status_irq_checker_asserts.sv ***
`timescale 1ns/1ps
module spi_status_irq_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [31:0] rdata,
    input wire logic slave_select_in,
    input wire logic miso_in,
    input wire logic mosi_out,
    input wire logic serial_clock_out,
    input wire logic [3:0] peripheral_select_out,
    input wire logic irq
);
    import spi_pkg::*;
    // ----------------------------------------
    // Register side
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence wr_to(logic [7:0] a);
        wr_en && addr == a;
    endsequence
    sequence rd_of(logic [7:0] a);
        rd_en && addr == a;
    endsequence
    a_rdata_quiet: assert property (!$past(rd_en) |-> rdata == 32'h0)
        else $error("read data outside answer cycle");
    a_mask_sets: assert property (wr_to(irq_enable_set_off) ##1 rd_of(irq_enable_state_off)
        |=> (rdata[9:0] & $past(wdata[9:0], 2)) == $past(wdata[9:0], 2))
        else $error("enable write did not set mask");
    a_mask_clears: assert property (wr_to(irq_enable_clear_off) ##1 rd_of(irq_enable_state_off)
        |=> (rdata[9:0] & $past(wdata[9:0], 2)) == 10'h000)
        else $error("disable write did not clear mask");
    a_irq_masked_off: assert property (rd_of(irq_enable_state_off) ##1 rdata[9:0] == 10'h000
        |-> !irq)
        else $error("interrupt with empty mask");
    a_enable_shows: assert property (wr_to(ctrl_off) && wdata[1:0] == 2'h1
        ##1 rd_of(status_off) |=> rdata[enabled_bit])
        else $error("enabled bit not set");
    a_disable_shows: assert property (wr_to(ctrl_off) && wdata[1] && peripheral_select_out == 4'hf
        ##1 rd_of(status_off) |=> !rdata[enabled_bit])
        else $error("enabled bit not cleared");
    a_tx_clears_empty: assert property (wr_to(tx_data_off) ##1 rd_of(status_off)
        |=> !rdata[shift_path_empty_bit])
        else $error("shift path empty after data write");
    // ----------------------------------------
    // Link side
    // ----------------------------------------
    a_single_select: assert property ($onehot0(~peripheral_select_out))
        else $error("more than one select active");
    // Config writes may move the idle level while nothing is selected
    a_clock_needs_sel: assert property ($changed(serial_clock_out) && !$past(wr_en)
        && !$past(wr_en, 2) |-> peripheral_select_out != 4'hf
        || $past(peripheral_select_out) != 4'hf)
        else $error("serial clock moved while idle");
endmodule // spi_status_irq_checker

bind spi_status_irq_chip_select spi_status_irq_checker u_checker (.clk(clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .slave_select_in(slave_select_in), .miso_in(miso_in), .mosi_out(mosi_out),
    .serial_clock_out(serial_clock_out), .peripheral_select_out(peripheral_select_out),
    .irq(irq));

// *** verification/spi_peer_model.sv ***
`timescale 1ns/1ps
module spi_peer_model (
    input wire logic sclk,
    input wire logic mosi,
    input wire logic sel_n,
    input wire logic idle_level,
    input wire logic phase_sel,
    input wire logic [15:0] reply,
    input wire logic [4:0] bit_total,
    output logic miso,
    output logic [15:0] heard
);
    // ----------------------------------------
    // Behavioural serial peer, most significant bit first
    // ----------------------------------------
    logic [15:0] out_sr;
    initial begin
        miso = 1'b0;
        heard = 16'h0000;
        out_sr = 16'h0000;
    end
    always @(negedge sel_n) begin
        out_sr = reply << (5'h10 - bit_total);
        heard = 16'h0000;
        if (phase_sel) begin
            miso = out_sr[15];
            out_sr = out_sr << 1;
        end
    end
    always @(sclk) begin
        if (!sel_n) begin
            if ((sclk != idle_level) ^ phase_sel) begin
                miso = out_sr[15];
                out_sr = out_sr << 1;
            end else begin
                heard = {heard[14:0], mosi};
            end
        end
    end
    // Released line must not look like held data
    always @(posedge sel_n) begin
        miso = ~miso;
    end
endmodule // spi_peer_model

// *** verification/spi_status_irq_chip_select_bench.sv ***
`timescale 1ns/1ps
module spi_status_irq_chip_select_bench;
    import spi_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic slave_select_in = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, v;
    logic miso_in, mosi_out, serial_clock_out, irq, prev_sclk;
    logic [3:0] peripheral_select_out, prev_sel;
    logic [15:0] heard;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    int t_fall = 0;
    int t_rise = 0;
    int edges[$];
    always #50 clk = ~clk;
    spi_status_irq_chip_select DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .slave_select_in(slave_select_in),
        .miso_in(miso_in), .mosi_out(mosi_out), .serial_clock_out(serial_clock_out),
        .peripheral_select_out(peripheral_select_out), .irq(irq));
    spi_peer_model peer (.sclk(serial_clock_out), .mosi(mosi_out),
        .sel_n(peripheral_select_out[0]), .idle_level(1'b0), .phase_sel(1'b1),
        .reply(16'h3c5a), .bit_total(5'h10), .miso(miso_in), .heard(heard));
    // ----------------------------------------
    // Tasks and monitors
    // ----------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        v = rdata;
        @(posedge clk);
    endtask
    task automatic wait_release();
        int i;
        int s;
        s = cyc;
        for (i = 0; i < 2000 && t_rise <= s; i++) @(posedge clk);
        @(posedge clk);
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Edges count only while selected, so idle-level moves are not taken as clocks
    always @(negedge clk) begin
        if (prev_sel === 4'hf && peripheral_select_out !== 4'hf) t_fall = cyc;
        if (prev_sel !== 4'hf && peripheral_select_out === 4'hf) t_rise = cyc;
        if (serial_clock_out !== prev_sclk && peripheral_select_out !== 4'hf && cyc != t_fall)
            edges.push_back(cyc);
        prev_sclk = serial_clock_out;
        prev_sel = peripheral_select_out;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            print_verdict();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(select_cfg0_off);
        chk("cfg0 reset", 32'h0, v);
        wr(8'hfc, 32'hffff_ffff);
        rd(8'hfc);
        chk("unmapped", 32'h0, v);
        wr(irq_enable_set_off, 32'h0000_03ff);
        rd(irq_enable_state_off);
        chk("mask all", 32'h0000_03ff, v);
        wr(irq_enable_clear_off, 32'h0000_0155);
        rd(irq_enable_state_off);
        chk("mask clear", 32'h0000_02aa, v);
        wr(irq_enable_set_off, 32'h0);
        rd(irq_enable_state_off);
        chk("mask keep", 32'h0000_02aa, v);
        wr(irq_enable_clear_off, 32'h0000_03ff);
        rd(irq_enable_state_off);
        chk("irq off", 32'h0, {31'h0, irq});
        slave_select_in <= 1'b1;
        repeat (4) @(posedge clk);
        wr(irq_enable_set_off, 32'h0000_0100);
        @(negedge clk);
        chk("irq on", 32'h1, {31'h0, irq});
        @(posedge clk);
        rd(status_off);
        chk("rise flag", 32'h1, {31'h0, v[select_in_rise_bit]});
        rd(status_off);
        chk("rise cleared", 32'h0, {31'h0, v[select_in_rise_bit]});
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(irq_enable_clear_off, 32'h0000_03ff);
        wr(ctrl_off, 32'h1);
        rd(status_off);
        chk("enabled", 32'h1, {31'h0, v[enabled_bit]});
        wr(select_cfg0_off, 32'h0105_0482);
        wr(select_cfg0_off + 8'h04, 32'h0000_0409);
        rd(select_cfg0_off);
        chk("cfg0 rw", 32'h0105_0482, v);
        wr(tx_data_off, 32'h0000_a5c3);
        rd(status_off);
        chk("empty cleared", 32'h0, {31'h0, v[shift_path_empty_bit]});
        wait_release();
        chk("edges 16", 32, edges.size());
        chk("lead", 5, edges[0] - t_fall);
        chk("period", 4, edges[2] - edges[0]);
        chk("gap", 1, (t_rise - edges[edges.size() - 1]) >= 32);
        chk("idle low", 32'h0, {31'h0, serial_clock_out});
        chk("mosi", 32'h0000_a5c3, {16'h0, heard});
        chk("released", 32'hf, {28'h0, peripheral_select_out});
        rd(rx_data_off);
        chk("miso", 32'h0000_3c5a, {16'h0, v[15:0]});
        rd(status_off);
        chk("empty set", 32'h1, {31'h0, v[shift_path_empty_bit]});
        edges.delete();
        wr(tx_data_off, 32'h0001_0055);
        repeat (100) @(posedge clk);
        chk("held", 32'hd, {28'h0, peripheral_select_out});
        chk("edges 8", 16, edges.size());
        chk("lead half", 2, edges[0] - t_fall);
        chk("idle high", 32'h1, {31'h0, serial_clock_out});
        edges.delete();
        wr(tx_data_off, 32'h0101_00aa);
        wait_release();
        chk("final release", 32'hf, {28'h0, peripheral_select_out});
        chk("edges final", 16, edges.size());
        wr(ctrl_off, 32'h3);
        rd(status_off);
        chk("disabled", 32'h0, {31'h0, v[enabled_bit]});
        print_verdict();
    end
endmodule // spi_status_irq_chip_select_bench
